// *** dv/bspc_host_mdl.sv ***
// bus side model: resolves the shared data and parity wire
`include "bspc_map.svh"
module bspc_host_mdl (
  // clock
  input  wire logic                    clk_i,
  // device and host drivers, {parity, data}
  input  wire logic                    dev_oe_i,
  input  wire logic [`BSPC_WORD_W-1:0] dev_w_i,
  input  wire logic                    host_oe_i,
  input  wire logic [`BSPC_WORD_W-1:0] host_w_i,
  // resolved wire
  output logic      [`BSPC_WORD_W-1:0] bus_w_o
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [`BSPC_WORD_W-1:0] last_ff = `BSPC_RST_WORD;
  // released wire shows the inverse of its last level
  always_comb begin
    if (dev_oe_i) begin
      bus_w_o = dev_w_i;
    end else if (host_oe_i) begin
      bus_w_o = host_w_i;
    end else begin
      bus_w_o = ~last_ff;
    end
  end
  // remember last wire level
  always @(posedge clk_i) begin
    last_ff <= bus_w_o;
  end
endmodule

// *** dv/bspc_top_sva.sv ***
// assertion checker on the pins of the burst sram port control block
`include "bspc_map.svh"
module bspc_top_sva (
  // clock and reset
  input wire logic                    clk_i,
  input wire logic                    rst_i,
  input wire logic                    ce_i,
  // strobes and selects
  input wire logic                    cpu_addr_strobe_n_i,
  input wire logic                    ctrl_addr_strobe_n_i,
  input wire logic                    chip_sel_low_a_n_i,
  input wire logic                    chip_sel_high_i,
  input wire logic                    chip_sel_low_b_n_i,
  // write, output enable, sleep
  input wire logic                    all_lanes_write_n_i,
  input wire logic                    lane_write_enable_n_i,
  input wire logic                    out_enable_n_i,
  input wire logic                    sleep_request_i,
  // data side outputs and read stream
  input wire logic [`BSPC_DATA_W-1:0] data_o,
  input wire logic                    data_oe_o,
  input wire logic                    parity_io_oe_o,
  input wire logic                    rd_valid_o,
  input wire logic [`BSPC_WORD_W-1:0] rd_word_o,
  input wire logic                    rd_ready_i
);
  timeunit 1ns;
  timeprecision 1ns;
  logic ld;
  logic sel_ok;
  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (rst_i);
  // ==========================================
  // load edge and select decode seen from the pins
  assign ld = ce_i && !sleep_request_i
           && ((!cpu_addr_strobe_n_i && !chip_sel_low_a_n_i) || !ctrl_addr_strobe_n_i);
  assign sel_ok = !chip_sel_low_a_n_i && chip_sel_high_i && !chip_sel_low_b_n_i;
  // ==========================================
  // pin properties
  property p_oe; out_enable_n_i |-> !data_oe_o; endproperty
  a_oe: assert property (p_oe) else $error("data driven with output enable high");
  property p_sleep_oe; sleep_request_i |-> !data_oe_o; endproperty
  a_sleep_oe: assert property (p_sleep_oe) else $error("data driven while asleep");
  property p_par; data_oe_o == parity_io_oe_o; endproperty
  a_par: assert property (p_par) else $error("parity drive differs from data drive");
  property p_desel; ld && !sel_ok |=> !data_oe_o; endproperty
  a_desel: assert property (p_desel) else $error("data driven while deselected");
  property p_first; ld && !sel_ok ##1 ld && sel_ok && !cpu_addr_strobe_n_i |=> !data_oe_o; endproperty
  a_first: assert property (p_first) else $error("first read clock not masked");
  property p_wr; ld && sel_ok && cpu_addr_strobe_n_i && !ctrl_addr_strobe_n_i && !all_lanes_write_n_i |=> !data_oe_o;
  endproperty
  a_wr: assert property (p_wr) else $error("data driven in write phase");
  property p_keep; data_oe_o && ce_i && !ld && all_lanes_write_n_i && lane_write_enable_n_i
    ##1 !out_enable_n_i && !sleep_request_i |-> data_oe_o; endproperty
  a_keep: assert property (p_keep) else $error("selects acted without a load");
  property p_sleep_hold; sleep_request_i && ce_i |=> $stable(data_o); endproperty
  a_sleep_hold: assert property (p_sleep_hold) else $error("read data moved while asleep");
  property p_buf; rd_valid_o && !rd_ready_i ##1 ce_i |-> rd_valid_o && $stable(rd_word_o); endproperty
  a_buf: assert property (p_buf) else $error("stalled read word lost");
endmodule
bind bspc_top bspc_top_sva chk_u (.*);

// *** dv/bspc_top_tb.sv ***
// self-checking bench of the burst sram port control block
`define BSPC_CHK(a, b) begin compares++; if ((a) !== (b)) begin errors++; $display("BAD %0t %h %h", $time, a, b); end end
module bspc_top_tb;
  timeunit 1ns;
  timeprecision 1ns;
  typedef struct packed { logic [3:0] a; logic [5:0] wr; logic [35:0] w; logic [35:0] e; } bspc_row_t;
  localparam logic [5:0] W = 6'h3F;
  localparam logic [2:0] OK = 3'b010;
  localparam logic [2:0] OFF = 3'b000;
  logic clk_i = 1'b0, rst_i = 1'b1, ce_i = 1'b1, cpu_addr_strobe_n_i = 1'b1, ctrl_addr_strobe_n_i = 1'b1;
  logic burst_advance_n_i = 1'b1, chip_sel_low_a_n_i = 1'b1, chip_sel_high_i = 1'b0, chip_sel_low_b_n_i = 1'b1;
  logic all_lanes_write_n_i = 1'b1, lane_write_enable_n_i = 1'b1, out_enable_n_i = 1'b1;
  logic sleep_request_i = 1'b0, burst_order_i = 1'b0, rd_ready_i = 1'b1, host_oe = 1'b1, data_oe_o, parity_io_oe_o;
  logic [3:0] addr_i = 4'h0, lane_write_select_n_i = 4'hF, parity_io_i, parity_io_o;
  logic [31:0] data_i, data_o;
  logic [35:0] host_w = 36'h0_0000_0000, bus_w, rd_word_o;
  logic rd_valid_o;
  int errors = 0, compares = 0, cycles = 0;
  bspc_row_t rows [4] = '{
    '{4'h4, 6'h1F, 36'h5_1111_2222, 36'h5_1111_2222},  // all lanes
    '{4'h5, 6'h2E, 36'hF_AABB_CCDD, 36'h1_0000_00DD},  // lane 0 only
    '{4'h6, 6'h25, 36'hA_8765_4321, 36'hA_8700_4300},  // lanes 1 and 3
    '{4'h7, 6'h30, 36'hF_FFFF_FFFF, 36'h0_0000_0000}}; // lane enable off
  // ==========================================
  // design, wire model and clock
  bspc_top dut_u (.*);
  bspc_host_mdl host_u (.clk_i(clk_i), .dev_oe_i(data_oe_o), .dev_w_i({parity_io_o, data_o}),
                        .host_oe_i(host_oe), .host_w_i(host_w), .bus_w_o(bus_w));
  assign {parity_io_i, data_i} = bus_w;
  always #25 clk_i = ~clk_i;
  // cycle ceiling
  always @(posedge clk_i) begin
    cycles++;
    if (cycles == 2000) begin
      errors++;
      end_sim();
    end
  end
  function automatic logic [35:0] wd(input logic [3:0] x);
    return {4'hC, 28'h000_0000, x};
  endfunction
  // one bus cycle; host drives the wire while output enable is off
  task automatic put(input logic cpu, input logic ctrl, input logic burst_advance, input logic [2:0] sel,
                     input logic [3:0] a, input logic [5:0] wr, input logic [35:0] w, input logic oe_n);
    @(posedge clk_i);
    cpu_addr_strobe_n_i <= cpu;
    ctrl_addr_strobe_n_i <= ctrl;
    burst_advance_n_i <= burst_advance;
    {chip_sel_low_a_n_i, chip_sel_high_i, chip_sel_low_b_n_i} <= sel;
    addr_i <= a;
    {all_lanes_write_n_i, lane_write_enable_n_i, lane_write_select_n_i} <= wr;
    host_w <= w;
    host_oe <= oe_n;
    out_enable_n_i <= oe_n;
  endtask
  task automatic end_sim;
    if (errors == 0 && compares > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask
  // ==========================================
  // main sequence
  initial begin
    repeat (8) @(posedge clk_i);
    #1 `BSPC_CHK({data_oe_o, rd_valid_o, data_o}, 34'h0_0000_0000)
    @(posedge clk_i);
    rst_i <= 1'b0;
    foreach (rows[i]) begin
      put(1, 0, 1, OK, rows[i].a, rows[i].wr, rows[i].w, 1);
      put(1, 0, 1, OFF, 4'h0, W, 36'h0, 1);
      put(0, 1, 1, OK, rows[i].a, W, 36'h0, 0);
      put(1, 1, 1, OFF, 4'h0, W, 36'h0, 0);
      #1 `BSPC_CHK({data_oe_o, parity_io_o, data_o}, {1'b0, rows[i].e})
      put(1, 1, 1, OFF, 4'h0, W, 36'h0, 0);
      #1 `BSPC_CHK(data_oe_o, 1'b1)
    end
    for (int m = 0; m < 2; m++) begin
      @(posedge clk_i);
      rst_i <= 1'b1;
      burst_order_i <= m[0];
      put(1, 1, 1, OFF, 4'h0, W, 36'h0, 1);
      rst_i <= 1'b0;
      for (int k = 4; k < 8; k++) put(1, 0, 1, OK, k[3:0], 6'h1F, wd(k[3:0]), 1);
      put(1, 0, 1, OFF, 4'h0, W, 36'h0, 1);
      put(0, 1, 1, OK, 4'h5, W, 36'h0, 0);
      for (int j = 0; j < 5; j++) begin
        put(1, 1, 0, OFF, 4'h0, W, 36'h0, 0);
        #1 `BSPC_CHK({parity_io_o, data_o}, wd({2'b01, m ? 2'(j) ^ 2'b01 : 2'(j + 1)}))
      end
    end
    put(0, 1, 1, 3'b110, 4'h2, W, 36'h0, 0);
    put(1, 1, 1, OFF, 4'h0, W, 36'h0, 0);
    #1 `BSPC_CHK({data_oe_o, parity_io_oe_o, parity_io_o, data_o}, {2'b11, wd(4'h4)})
    put(1, 1, 0, OFF, 4'h0, W, 36'h0, 0);
    ce_i <= 1'b0;
    repeat (2) put(1, 1, 0, OFF, 4'h0, W, 36'h0, 0);
    #1 `BSPC_CHK({data_oe_o, rd_valid_o, parity_io_o, data_o}, {2'b10, wd(4'h4)})
    put(1, 1, 0, OFF, 4'h0, W, 36'h0, 0);
    ce_i <= 1'b1;
    sleep_request_i <= 1'b1;
    repeat (2) put(1, 1, 0, OFF, 4'h0, W, 36'h0, 0);
    #1 `BSPC_CHK({data_oe_o, parity_io_o, data_o}, {1'b0, wd(4'h4)})
    put(0, 0, 1, OK, 4'h4, 6'h1F, 36'h0, 1);
    sleep_request_i <= 1'b0;
    put(1, 0, 1, OFF, 4'h0, W, 36'h0, 1);
    rd_ready_i <= 1'b0;
    put(0, 1, 1, OK, 4'h4, W, 36'h0, 0);
    repeat (4) put(1, 1, 1, OFF, 4'h0, W, 36'h0, 0);
    put(1, 0, 1, OFF, 4'h0, W, 36'h0, 1);
    rd_ready_i <= 1'b1;
    #1 `BSPC_CHK({rd_valid_o, rd_word_o}, {1'b1, 36'h8_0400_0004})
    put(1, 1, 1, OFF, 4'h0, W, 36'h0, 1);
    #1 `BSPC_CHK({rd_valid_o, rd_word_o}, {1'b1, 36'h8_0400_0004})
    put(1, 1, 1, OFF, 4'h0, W, 36'h0, 1);
    #1 `BSPC_CHK(rd_valid_o, 1'b0)
    end_sim();
  end
endmodule

// *** rtl/bspc_buf.sv ***
// two-entry valid/ready buffer for read words
`include "bspc_map.svh"
module bspc_buf (
  // clock and reset
  input  wire logic         clk_i,
  input  wire logic         rst_i,
  input  wire logic         ce_i,
  // filling side
  bspc_stream_if.snk        in_s,
  // draining side
  output logic              out_valid_o,
  output bspc_pkg::bspc_word_t out_data_o,
  input  wire logic         out_ready_i
);
  bspc_pkg::bspc_buf_regs_t regs_ff;
  bspc_pkg::bspc_buf_regs_t nxt_regs;
  logic                     push;
  logic                     pop;

  // handshakes, full and empty from the count
  assign in_s.ready  = ce_i && (regs_ff.cnt != 2'(`BSPC_BUF_DEPTH));
  assign out_valid_o = ce_i && (regs_ff.cnt != 2'h0);
  assign out_data_o  = regs_ff.slot[regs_ff.rp];
  assign push        = in_s.valid && in_s.ready;
  assign pop         = out_valid_o && out_ready_i;

  // next state
  always_comb begin
    nxt_regs = regs_ff;
    if (push) begin
      nxt_regs.slot[regs_ff.wp] = in_s.data;
      nxt_regs.wp               = ~regs_ff.wp;
    end
    if (pop) begin
      nxt_regs.rp = ~regs_ff.rp;
    end
    if (push && !pop) begin
      nxt_regs.cnt = regs_ff.cnt + 2'h1;
    end else if (pop && !push) begin
      nxt_regs.cnt = regs_ff.cnt - 2'h1;
    end
  end

  // state register
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      regs_ff <= '0;
    end else if (ce_i) begin
      regs_ff <= nxt_regs;
    end
  end
endmodule

// *** rtl/bspc_map.svh ***
// constants of the burst sram port control block
`ifndef BSPC_MAP_SVH
`define BSPC_MAP_SVH
// ==========================================
// widths and depths
`define BSPC_LANES     4
`define BSPC_LANE_W    8
`define BSPC_SLICE_W   9
`define BSPC_DATA_W    32
`define BSPC_WORD_W    36
`define BSPC_AW        4
`define BSPC_DEPTH     16
`define BSPC_BUF_DEPTH 2
// ==========================================
// reset values, lane masks and counter step
`define BSPC_RST_WORD  36'h0_0000_0000
`define BSPC_RST_ADDR  4'h0
`define BSPC_RST_CNT   2'h0
`define BSPC_NO_LANES  4'h0
`define BSPC_ALL_LANES 4'hF
`define BSPC_CNT_STEP  2'h1
`endif

// *** rtl/bspc_pkg.sv ***
// types of the burst sram port control block
`include "bspc_map.svh"
package bspc_pkg;
  // ==========================================
  // port state
  typedef enum logic [0:0] {
    bspc_st_desel = 1'b0,
    bspc_st_sel   = 1'b1
  } bspc_state_t;

  typedef logic [`BSPC_WORD_W-1:0] bspc_word_t;

  // all flip-flops of the port
  typedef struct packed {
    bspc_state_t                  st;
    logic [`BSPC_AW-1:0]          addr;
    logic [1:0]                   start;
    logic [1:0]                   cnt;
    logic                         first;
    logic                         wr_phase;
    bspc_word_t                   rdata;
    bspc_word_t [`BSPC_DEPTH-1:0] mem;
  } bspc_regs_t;

  // all flip-flops of the two-entry buffer
  typedef struct packed {
    bspc_word_t [`BSPC_BUF_DEPTH-1:0] slot;
    logic                             wp;
    logic                             rp;
    logic [1:0]                       cnt;
  } bspc_buf_regs_t;
endpackage

// *** rtl/bspc_stream_if.sv ***
// word stream between the port and its buffer
interface bspc_stream_if;
  logic              valid;
  logic              ready;
  bspc_pkg::bspc_word_t data;
  modport src (output valid, output data, input ready);
  modport snk (input valid, input data, output ready);
endinterface

// *** rtl/bspc_top.sv ***
// burst sram port control: strobes, burst counter, array and data pins
`include "bspc_map.svh"
module bspc_top (
  // clock, reset, enable
  input  wire logic                       clk_i,
  input  wire logic                       rst_i,
  input  wire logic                       ce_i,
  // address and strobes
  input  wire logic [`BSPC_AW-1:0]        addr_i,
  input  wire logic                       cpu_addr_strobe_n_i,
  input  wire logic                       ctrl_addr_strobe_n_i,
  input  wire logic                       burst_advance_n_i,
  // chip selects
  input  wire logic                       chip_sel_low_a_n_i,
  input  wire logic                       chip_sel_high_i,
  input  wire logic                       chip_sel_low_b_n_i,
  // write controls
  input  wire logic                       all_lanes_write_n_i,
  input  wire logic                       lane_write_enable_n_i,
  input  wire logic [`BSPC_LANES-1:0]     lane_write_select_n_i,
  // output enable, sleep, burst order strap
  input  wire logic                       out_enable_n_i,
  input  wire logic                       sleep_request_i,
  input  wire logic                       burst_order_i,
  // data pins, split
  input  wire logic [`BSPC_DATA_W-1:0]    data_i,
  output logic      [`BSPC_DATA_W-1:0]    data_o,
  output logic                            data_oe_o,
  // parity pins, split
  input  wire logic [`BSPC_LANES-1:0]     parity_io_i,
  output logic      [`BSPC_LANES-1:0]     parity_io_o,
  output logic                            parity_io_oe_o,
  // buffered read word stream
  output logic                            rd_valid_o,
  output logic      [`BSPC_WORD_W-1:0]    rd_word_o,
  input  wire logic                       rd_ready_i
);
  // ==========================================
  // declarations
  bspc_pkg::bspc_regs_t    regs_ff;
  bspc_pkg::bspc_regs_t    nxt_regs;
  bspc_stream_if           rd_s ();
  logic                    run;
  logic                    cs_ok;
  logic                    cpu_load;
  logic                    ctrl_load;
  logic                    load;
  logic                    sel_now;
  logic                    wr_req;
  logic                    do_write;
  logic [`BSPC_LANES-1:0]  lanes;
  logic [1:0]              low_bits;
  logic [1:0]              eff_cnt;
  logic [`BSPC_AW-1:0]     cur_idx;
  logic [`BSPC_AW-1:0]     acc_idx;
  logic                    rd_phase;
  logic                    stall;
  logic                    may_advance;
  logic                    drive;

  // ==========================================
  // qualification of the strobes
  // sleep freezes the port registers, contents stay; the read buffer still drains on ce_i
  assign run = ce_i && !sleep_request_i;

  // select decode of the three chip selects
  assign cs_ok = !chip_sel_low_a_n_i && chip_sel_high_i
                 && !chip_sel_low_b_n_i;

  // processor strobe needs first select low
  assign cpu_load = !cpu_addr_strobe_n_i && !chip_sel_low_a_n_i;

  // processor strobe wins over the controller strobe
  assign ctrl_load = !ctrl_addr_strobe_n_i && !cpu_load;

  assign load = cpu_load || ctrl_load;

  // selects only count on a load cycle
  assign sel_now = load ? cs_ok
                        : (regs_ff.st == bspc_pkg::bspc_st_sel);

  // ==========================================
  // burst address
  // an advancing edge already reads the next beat, no extra stage
  assign eff_cnt = may_advance ? regs_ff.cnt + `BSPC_CNT_STEP
                               : regs_ff.cnt;

  // strap high interleaves, low counts up, both wrap by four
  assign low_bits = burst_order_i ? (regs_ff.start ^ eff_cnt)
                                  : (regs_ff.start + eff_cnt);

  // counter bits replace the two low address bits
  assign cur_idx = {regs_ff.addr[`BSPC_AW-1:2], low_bits};

  // a load cycle works on the new address at once
  assign acc_idx = load ? addr_i : cur_idx;

  // ==========================================
  // write decode
  // all lanes write overrides the lane controls
  always_comb begin
    if (!all_lanes_write_n_i) begin
      lanes = `BSPC_ALL_LANES;
    end else if (!lane_write_enable_n_i) begin
      lanes = ~lane_write_select_n_i;
    end else begin
      lanes = `BSPC_NO_LANES;
    end
  end

  assign wr_req = (lanes != `BSPC_NO_LANES);

  // the processor load cycle ignores the write inputs
  assign do_write = sel_now && wr_req && !cpu_load;

  // ==========================================
  // read stream and stall
  // a read data phase offers the presented word to the buffer
  assign rd_phase   = run && (regs_ff.st == bspc_pkg::bspc_st_sel)
                      && !regs_ff.wr_phase;
  assign rd_s.valid = rd_phase;
  assign rd_s.data  = regs_ff.rdata;

  // a full buffer holds the burst so no word is skipped
  assign stall = rd_phase && !rd_s.ready;

  assign may_advance = !load && sel_now && !burst_advance_n_i
                       && !stall;

  // ==========================================
  // pin drive
  // output enable low drives, masked on write, deselect and first read
  assign drive = !out_enable_n_i
                 && !sleep_request_i
                 && (regs_ff.st == bspc_pkg::bspc_st_sel)
                 && !regs_ff.wr_phase
                 && !regs_ff.first;

  // data and parity share one enable and one register
  assign data_oe_o      = drive;
  assign parity_io_oe_o = drive;

  // unpack the lanes of the read register
  always_comb begin
    for (int k = 0; k < `BSPC_LANES; k++) begin
      data_o[k*`BSPC_LANE_W +: `BSPC_LANE_W] =
        regs_ff.rdata[k*`BSPC_SLICE_W +: `BSPC_LANE_W];
      parity_io_o[k] =
        regs_ff.rdata[k*`BSPC_SLICE_W + `BSPC_LANE_W];
    end
  end

  // ==========================================
  // next state
  always_comb begin
    nxt_regs = regs_ff;

    // new address: capture and seed the counter
    if (load) begin
      nxt_regs.addr  = addr_i;
      nxt_regs.start = addr_i[1:0];
      nxt_regs.cnt   = `BSPC_RST_CNT;
    end else if (may_advance) begin
      nxt_regs.cnt = eff_cnt;
    end

    // select state changes only on a load
    case (regs_ff.st)
      bspc_pkg::bspc_st_desel: begin
        if (load && cs_ok) begin
          nxt_regs.st = bspc_pkg::bspc_st_sel;
        end
      end
      bspc_pkg::bspc_st_sel: begin
        if (load && !cs_ok) begin
          nxt_regs.st = bspc_pkg::bspc_st_desel;
        end
      end
      default: begin
        nxt_regs.st = bspc_pkg::bspc_st_desel;
      end
    endcase

    // first clock out of deselect keeps the pins off
    nxt_regs.first = load && cs_ok
                     && (regs_ff.st == bspc_pkg::bspc_st_desel)
                     && !do_write;

    // a write cycle keeps the pins off in its data phase
    nxt_regs.wr_phase = do_write;

    // capture the input lines lane by lane
    if (do_write) begin
      for (int k = 0; k < `BSPC_LANES; k++) begin
        if (lanes[k]) begin
          nxt_regs.mem[acc_idx][k*`BSPC_SLICE_W +: `BSPC_SLICE_W] =
            {parity_io_i[k], data_i[k*`BSPC_LANE_W +: `BSPC_LANE_W]};
        end
      end
    end

    // flow-through read, held while the buffer is full
    if (sel_now && !stall) begin
      nxt_regs.rdata = regs_ff.mem[acc_idx];
    end
  end

  // ==========================================
  // state register
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      regs_ff       <= '0;
      regs_ff.st    <= bspc_pkg::bspc_st_desel;
      regs_ff.addr  <= `BSPC_RST_ADDR;
      regs_ff.rdata <= `BSPC_RST_WORD;
    end else if (run) begin
      regs_ff <= nxt_regs;
    end
  end

  // ==========================================
  // read word buffer
  bspc_buf u_buf (
    .clk_i       (clk_i),
    .rst_i       (rst_i),
    .ce_i        (ce_i),
    .in_s        (rd_s.snk),
    .out_valid_o (rd_valid_o),
    .out_data_o  (rd_word_o),
    .out_ready_i (rd_ready_i)
  );
endmodule
